// File: common/fsd_regs.vh
// Register offsets, bit positions and reset values of the fault status bank.
`ifndef FSD_REGS_VH
`define FSD_REGS_VH
`define FSD_ADDR_STATUS_A 8'h42
`define FSD_ADDR_STATUS_B 8'h43
`define FSD_ADDR_SCAN_SEL 8'h46
`define FSD_ADDR_SHORT_THR 8'h47
`define FSD_RST_STATUS 8'h00
`define FSD_RST_SCAN_SEL 8'h00
`define FSD_RST_SHORT_THR 8'h37
`define FSD_BIT_IN1_SCAN 7
`define FSD_BIT_IN2_SCAN 6
`define FSD_BIT_INCL_SE 5
`define FSD_BIT_INCL_AC 4
`define FSD_BIT_OUT1P_SCAN 3
`define FSD_BIT_OUT1M_SCAN 2
`define FSD_BIT_OUT2P_SCAN 1
`define FSD_BIT_OUT2M_SCAN 0
`define FSD_ZERO1 1'h0
`define FSD_ZERO8 8'h00
`endif

// File: verif/fsd_properties.sv
// Checker for the fault status register bank.
`timescale 1ns/1ps
`default_nettype none
module fsd_properties (
  input wire logic clk,
  input wire logic rstn,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic headset_insert,
  input wire logic headset_remove,
  input wire logic headset_hook,
  input wire logic input_pair1_scan_enable,
  input wire logic output2_neg_scan_enable,
  input wire logic [7:0] short_threshold_value
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire rd_a = reg_read && reg_addr == 8'h42;
  wire wr_s = reg_write && reg_addr == 8'h46;
  wire wr_t = reg_write && reg_addr == 8'h47;
  chk_scan_write: assert property (wr_s |=>
    input_pair1_scan_enable == $past(reg_wdata[7]) &&
    output2_neg_scan_enable == $past(reg_wdata[0])) else $error("scan");
  chk_scan_hold: assert property (!wr_s |=>
    $stable(input_pair1_scan_enable)) else $error("scan hold");
  chk_insert_bit: assert property (rd_a |=>
    reg_rdata[3] == $past(headset_insert, 2)) else $error("insert");
  chk_remove_hook: assert property (rd_a |=>
    reg_rdata[2] == ($past(headset_remove, 2) | $past(headset_hook, 2)))
    else $error("remove");
  chk_reserved_zero: assert property (rd_a |=> !reg_rdata[0])
    else $error("reserved");
  chk_unmapped_zero: assert property (reg_read && reg_addr == 8'h44 |=>
    reg_rdata == 8'h00) else $error("unmapped");
  chk_thr_write: assert property (wr_t |=>
    short_threshold_value == $past(reg_wdata)) else $error("threshold");
  chk_rdata_hold: assert property (!reg_read |=> $stable(reg_rdata))
    else $error("rdata hold");
  chk_rvalid_pulse: assert property (reg_rvalid == $past(reg_read))
    else $error("rvalid");
  cover property (rd_a);
  cover property (wr_s);
  cover property (reg_read && reg_addr == 8'h43);
endmodule
bind fsd_status_regs fsd_properties i_props (.*);
`default_nettype wire

// File: verif/fsd_status_regs_bench.sv
// Self-checking bench for the fault status register bank.
`timescale 1ns/1ps
`default_nettype none
module fsd_status_regs_bench;
  logic clk, rstn, reg_write, reg_read, reg_rvalid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, short_threshold_value;
  logic ch1_single_ended, ch2_single_ended, ch1_ac_coupled, ch2_ac_coupled;
  logic ch1_pos_overvoltage, ch1_neg_overvoltage;
  logic ch2_pos_overvoltage, ch2_neg_overvoltage;
  logic headset_insert, headset_remove, headset_hook;
  logic processor_load_overload, monitor_above_upper, monitor_below_lower;
  logic voice_power_up, voice_power_down, bias_short, bias_high_current;
  logic bias_low_current, bias_overvoltage;
  logic input_pair1_scan_enable, input_pair2_scan_enable;
  logic include_single_ended_negative, include_ac_coupled_pins;
  logic output1_pos_scan_enable, output1_neg_scan_enable;
  logic output2_pos_scan_enable, output2_neg_scan_enable;
  int err_count = 0;
  int checked = 0;
  logic [7:0] a, s, e;
  logic [19:0] v;
  // Row: read address, scan select, {cfg, faults, headset, status B}, read.
  logic [43:0] rows [13] = '{44'h43_00_000a5_a5, 44'h43_00_0005a_5a,
    44'h42_80_0f000_c0, 44'h42_40_0f000_30, 44'h42_c0_8f000_b0,
    44'h42_e0_8f000_f0, 44'h42_c0_1f000_c0, 44'h42_d0_1f000_f0,
    44'h42_00_00a00_0c, 44'h42_00_00500_06, 44'h46_0f_00000_0f,
    44'h46_5a_00000_5a, 44'h44_f0_00000_00};
  wire [7:0] sel_out = {input_pair1_scan_enable, input_pair2_scan_enable,
    include_single_ended_negative, include_ac_coupled_pins,
    output1_pos_scan_enable, output1_neg_scan_enable,
    output2_pos_scan_enable, output2_neg_scan_enable};
  fsd_status_regs i_dut (.*);
  task automatic chk(input string n, input logic [7:0] got, exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic set_in(input logic [19:0] x);
    {ch1_single_ended, ch2_single_ended, ch1_ac_coupled, ch2_ac_coupled,
     ch1_pos_overvoltage, ch1_neg_overvoltage, ch2_pos_overvoltage,
     ch2_neg_overvoltage, headset_insert, headset_remove, headset_hook,
     processor_load_overload, monitor_above_upper, monitor_below_lower,
     voice_power_up, voice_power_down, bias_short, bias_high_current,
     bias_low_current, bias_overvoltage} = x;
  endtask
  // Strobes last exactly one clock, so the reply is seen at the next fall.
  task automatic acc(input logic w, input logic [7:0] ad, d);
    @(negedge clk);
    {reg_write, reg_read, reg_addr, reg_wdata} = {w, !w, ad, d};
    @(negedge clk);
    {reg_write, reg_read} = 2'b00;
    chk("rvalid", {7'h00, reg_rvalid}, {7'h00, !w});
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial begin
    #8000;
    err_count++;
    conclude();
  end
  initial begin
    {rstn, reg_write, reg_read, reg_addr, reg_wdata} = 18'h0;
    set_in(20'h0);
    repeat (5) @(negedge clk);
    rstn = 1;
    for (int i = 0; i < 13; i++) begin
      {a, s, v, e} = rows[i];
      acc(1, 8'h46, s);
      set_in(v);
      repeat (2) @(negedge clk);
      acc(0, a, 8'h00);
      chk("rdata", reg_rdata, e);
      chk("scan", sel_out, s);
      $display("row %0d done", i);
    end
    acc(1, 8'h42, 8'hff);
    acc(0, 8'h42, 8'h00);
    chk("ro_a", reg_rdata, 8'h00);
    acc(1, 8'h47, 8'ha5);
    chk("thr", short_threshold_value, 8'ha5);
    // Let an edge pass so the strobes are not driven twice in one step.
    @(negedge clk);
    {reg_write, reg_read, reg_addr, reg_wdata} = {2'b11, 8'h46, 8'h3c};
    @(negedge clk);
    {reg_write, reg_read} = 2'b00;
    chk("rd_old", reg_rdata, 8'hf0);
    chk("wr_new", sel_out, 8'h3c);
    rstn = 0;
    @(negedge clk);
    chk("rst_sel", sel_out, 8'h00);
    chk("rst_thr", short_threshold_value, 8'h37);
    rstn = 1;
    acc(0, 8'h43, 8'h00);
    chk("rst_b", reg_rdata, 8'h00);
    $display("hand tests done");
    conclude();
  end
endmodule
`default_nettype wire

// File: verilog/fsd_pin_gate.v
// Gating of one input channel's over-voltage faults by its scan selection.
`timescale 1ns/1ps
`default_nettype none
module fsd_pin_gate (
  input wire scan_enable,
  input wire include_single_ended_negative,
  input wire include_ac_coupled_pins,
  input wire single_ended,
  input wire ac_coupled,
  input wire pos_fault,
  input wire neg_fault,
  output wire pos_gated,
  output wire neg_gated
);
  wire chan_in_scan;
  // An AC-coupled channel is only scanned when explicitly included.
  assign chan_in_scan = scan_enable & (~ac_coupled | include_ac_coupled_pins);
  assign pos_gated = chan_in_scan & pos_fault;
  // The negative pin of a single-ended channel needs its own inclusion.
  assign neg_gated = chan_in_scan & neg_fault &
    (~single_ended | include_single_ended_negative);
endmodule
`default_nettype wire

// File: verilog/fsd_status_regs.v
// Live fault status and diagnostic scan selection register bank.
`timescale 1ns/1ps
`default_nettype none
`include "fsd_regs.vh"
// Behaviour
// - Status A bits 7,6: channel-1 over-voltage
// - Status A bits 5,4: channel-2 over-voltage
// - Status A bit 3: headset insert
// - Status A bit 2: headset removal
// - Bit 2 ORs removal with hook
// - Bit 1 processor overload; bit 0 zero
// - Status B bit 7: monitor above upper
// - Status B bit 6: monitor below lower
// - Status B bit 5: voice power-up
// - Status B bit 4: voice power-down
// - Status B bit 3: bias short circuit
// - Status B bit 2: bias high current
// - Status B bit 1: bias low current
// - Status B bit 0: bias over-voltage
// - Select bit 7: channel-1 input scan
// - Select bit 6: channel-2 input scan
// - Select bit 5: include single-ended negatives
// - Select bit 4: include AC-coupled pins
// - Select bit 3: output-1 positive scan
// - Select bit 2: output-1 negative scan
// - Select bits 1,0: output-2 scans
module fsd_status_regs (
  input wire clk,
  input wire rstn,
  input wire reg_write,
  input wire reg_read,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output reg reg_rvalid,
  input wire ch1_single_ended,
  input wire ch2_single_ended,
  input wire ch1_ac_coupled,
  input wire ch2_ac_coupled,
  input wire ch1_pos_overvoltage,
  input wire ch1_neg_overvoltage,
  input wire ch2_pos_overvoltage,
  input wire ch2_neg_overvoltage,
  input wire headset_insert,
  input wire headset_remove,
  input wire headset_hook,
  input wire processor_load_overload,
  input wire monitor_above_upper,
  input wire monitor_below_lower,
  input wire voice_power_up,
  input wire voice_power_down,
  input wire bias_short,
  input wire bias_high_current,
  input wire bias_low_current,
  input wire bias_overvoltage,
  output wire input_pair1_scan_enable,
  output wire input_pair2_scan_enable,
  output wire include_single_ended_negative,
  output wire include_ac_coupled_pins,
  output wire output1_pos_scan_enable,
  output wire output1_neg_scan_enable,
  output wire output2_pos_scan_enable,
  output wire output2_neg_scan_enable,
  output wire [7:0] short_threshold_value
);
  reg [7:0] diagnostic_scan_select;
  reg [7:0] short_threshold_config_a;
  reg [7:0] live_event_status_a;
  reg [7:0] live_event_status_b;
  wire ch1_pos_gated;
  wire ch1_neg_gated;
  wire ch2_pos_gated;
  wire ch2_neg_gated;
  wire [7:0] next_status_a;
  wire [7:0] next_status_b;
  reg [7:0] next_rdata;

  assign input_pair1_scan_enable =
    diagnostic_scan_select[`FSD_BIT_IN1_SCAN];
  assign input_pair2_scan_enable =
    diagnostic_scan_select[`FSD_BIT_IN2_SCAN];
  assign include_single_ended_negative =
    diagnostic_scan_select[`FSD_BIT_INCL_SE];
  assign include_ac_coupled_pins =
    diagnostic_scan_select[`FSD_BIT_INCL_AC];
  assign output1_pos_scan_enable =
    diagnostic_scan_select[`FSD_BIT_OUT1P_SCAN];
  assign output1_neg_scan_enable =
    diagnostic_scan_select[`FSD_BIT_OUT1M_SCAN];
  assign output2_pos_scan_enable =
    diagnostic_scan_select[`FSD_BIT_OUT2P_SCAN];
  assign output2_neg_scan_enable =
    diagnostic_scan_select[`FSD_BIT_OUT2M_SCAN];
  assign short_threshold_value = short_threshold_config_a;

  fsd_pin_gate u_gate1 (
    .scan_enable(input_pair1_scan_enable),
    .include_single_ended_negative(include_single_ended_negative),
    .include_ac_coupled_pins(include_ac_coupled_pins),
    .single_ended(ch1_single_ended),
    .ac_coupled(ch1_ac_coupled),
    .pos_fault(ch1_pos_overvoltage),
    .neg_fault(ch1_neg_overvoltage),
    .pos_gated(ch1_pos_gated),
    .neg_gated(ch1_neg_gated)
  );

  fsd_pin_gate u_gate2 (
    .scan_enable(input_pair2_scan_enable),
    .include_single_ended_negative(include_single_ended_negative),
    .include_ac_coupled_pins(include_ac_coupled_pins),
    .single_ended(ch2_single_ended),
    .ac_coupled(ch2_ac_coupled),
    .pos_fault(ch2_pos_overvoltage),
    .neg_fault(ch2_neg_overvoltage),
    .pos_gated(ch2_pos_gated),
    .neg_gated(ch2_neg_gated)
  );

  // Removal and hook share one bit, so either event raises it.
  assign next_status_a = {
    ch1_pos_gated,
    ch1_neg_gated,
    ch2_pos_gated,
    ch2_neg_gated,
    headset_insert,
    headset_remove | headset_hook,
    processor_load_overload,
    `FSD_ZERO1
  };

  assign next_status_b = {
    monitor_above_upper,
    monitor_below_lower,
    voice_power_up,
    voice_power_down,
    bias_short,
    bias_high_current,
    bias_low_current,
    bias_overvoltage
  };

  // Status is resampled every cycle; there is nothing to clear.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      live_event_status_a <= `FSD_RST_STATUS;
      live_event_status_b <= `FSD_RST_STATUS;
    end else begin
      live_event_status_a <= next_status_a;
      live_event_status_b <= next_status_b;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      diagnostic_scan_select <= `FSD_RST_SCAN_SEL;
      short_threshold_config_a <= `FSD_RST_SHORT_THR;
    end else if (reg_write) begin
      if (reg_addr == `FSD_ADDR_SCAN_SEL)
        diagnostic_scan_select <= reg_wdata;
      if (reg_addr == `FSD_ADDR_SHORT_THR)
        short_threshold_config_a <= reg_wdata;
    end
  end

  always @* begin
    case (reg_addr)
      `FSD_ADDR_STATUS_A: next_rdata = live_event_status_a;
      `FSD_ADDR_STATUS_B: next_rdata = live_event_status_b;
      `FSD_ADDR_SCAN_SEL: next_rdata = diagnostic_scan_select;
      `FSD_ADDR_SHORT_THR: next_rdata = short_threshold_config_a;
      default: next_rdata = `FSD_ZERO8;
    endcase
  end

  // Read data is registered so it holds steady between reads.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= `FSD_ZERO8;
      reg_rvalid <= `FSD_ZERO1;
    end else begin
      reg_rvalid <= reg_read;
      if (reg_read)
        reg_rdata <= next_rdata;
    end
  end
endmodule
`default_nettype wire
